/* rtl/iopt_top.v */
`timescale 1ns/1ps
`include "iopt_defs.vh"

module iopt_top #(
   parameter PA_W = `IOPT_PA_W,
   parameter PB_W = `IOPT_PB_W,
   parameter PC_W = `IOPT_PC_W,
   parameter WAKE_EN = 1'b1,
   parameter TONE_EN = 1'b1,
   parameter PULLUP_EN = 1'b1
) (
   input wire i_mclk,
   input wire i_rstn,
   input wire [`IOPT_ADDR_W-1:0] i_addr,
   input wire i_wr,
   input wire [7:0] i_wdata,
   input wire i_rd,
   input wire i_bit_op,
   input wire [1:0] i_bit_cmd,
   input wire [2:0] i_bit_sel,
   input wire i_timer_ovf,
   input wire i_halted,
   input wire [PA_W-1:0] i_pa_pad,
   input wire [PB_W-1:0] i_pb_pad,
   input wire [PC_W-1:0] i_pc_pad,
   output reg [7:0] o_rdata,
   output reg o_rvalid,
   output wire [PA_W-1:0] o_pa_pad,
   output wire [PA_W-1:0] o_pa_oe,
   output wire [PB_W-1:0] o_pb_pad,
   output wire [PB_W-1:0] o_pb_oe,
   output wire [PC_W-1:0] o_pc_pad,
   output wire [PC_W-1:0] o_pc_oe,
   output reg o_pullup_en,
   output reg o_wake,
   output reg o_ext_int,
   output reg o_timer_in
);
   localparam CMD_SET = 2'h0;
   localparam CMD_CLR = 2'h1;
   localparam CMD_CPL = 2'h2;

   reg rst_meta_reg;
   reg rst_sync_reg;
   wire rst_n;

   always @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   reg [PA_W-1:0] pa_data_reg;
   reg [PA_W-1:0] pa_dir_reg;
   reg [PB_W-1:0] pb_data_reg;
   reg [PB_W-1:0] pb_dir_reg;
   reg [PC_W-1:0] pc_data_reg;
   reg [PC_W-1:0] pc_dir_reg;
   reg tone_reg;

   wire [PA_W-1:0] pa_rd;
   wire [PB_W-1:0] pb_rd;
   wire [PC_W-1:0] pc_rd;
   wire [PA_W-1:0] pa_sync;
   wire [PB_W-1:0] pb_sync;
   wire [PC_W-1:0] pc_sync;
   wire [PB_W-1:0] pb_alt_en;
   wire [PB_W-1:0] pb_alt_val;

   // Tone source: toggles on every overflow of the external timer
   always @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         tone_reg <= 1'b0;
      end else if (i_timer_ovf) begin
         tone_reg <= ~tone_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < PA_W; g = g + 1) begin : g_pa
         iopt_pin u_pin (
            .i_mclk(i_mclk),
            .i_rst_n(rst_n),
            .i_pad(i_pa_pad[g]),
            .i_dir(pa_dir_reg[g]),
            .i_latch(pa_data_reg[g]),
            .i_alt_en(1'b0),
            .i_alt_val(1'b0),
            .o_pad(o_pa_pad[g]),
            .o_pad_oe(o_pa_oe[g]),
            .o_rd(pa_rd[g]),
            .o_sync(pa_sync[g])
         );
      end
      for (g = 0; g < PB_W; g = g + 1) begin : g_pb
         // Tone pair replaces latch data whenever TONE_EN is set, on input and output lines alike
         if (g == `IOPT_TONE_BIT0) begin : g_t0
            assign pb_alt_en[g] = (TONE_EN != 0);
            assign pb_alt_val[g] = pb_data_reg[`IOPT_TONE_BIT0] &
               tone_reg;
         end else if (g == `IOPT_TONE_BIT1) begin : g_t1
            assign pb_alt_en[g] = (TONE_EN != 0);
            assign pb_alt_val[g] = pb_data_reg[`IOPT_TONE_BIT0] &
               ~tone_reg;
         end else begin : g_tn
            assign pb_alt_en[g] = 1'b0;
            assign pb_alt_val[g] = 1'b0;
         end
         iopt_pin u_pin (
            .i_mclk(i_mclk),
            .i_rst_n(rst_n),
            .i_pad(i_pb_pad[g]),
            .i_dir(pb_dir_reg[g]),
            .i_latch(pb_data_reg[g]),
            .i_alt_en(pb_alt_en[g]),
            .i_alt_val(pb_alt_val[g]),
            .o_pad(o_pb_pad[g]),
            .o_pad_oe(o_pb_oe[g]),
            .o_rd(pb_rd[g]),
            .o_sync(pb_sync[g])
         );
      end
      for (g = 0; g < PC_W; g = g + 1) begin : g_pc
         iopt_pin u_pin (
            .i_mclk(i_mclk),
            .i_rst_n(rst_n),
            .i_pad(i_pc_pad[g]),
            .i_dir(pc_dir_reg[g]),
            .i_latch(pc_data_reg[g]),
            .i_alt_en(1'b0),
            .i_alt_val(1'b0),
            .o_pad(o_pc_pad[g]),
            .o_pad_oe(o_pc_oe[g]),
            .o_rd(pc_rd[g]),
            .o_sync(pc_sync[g])
         );
      end
   endgenerate

   // Read value of the addressed location, upper missing bits zero
   reg [7:0] port_rd;
   always @* begin
      port_rd = 8'h00;
      if (i_addr == `IOPT_ADDR_PA_DATA) begin
         port_rd[PA_W-1:0] = pa_rd;
      end else if (i_addr == `IOPT_ADDR_PA_DIR) begin
         port_rd[PA_W-1:0] = pa_dir_reg;
      end else if (i_addr == `IOPT_ADDR_PB_DATA) begin
         port_rd[PB_W-1:0] = pb_rd;
      end else if (i_addr == `IOPT_ADDR_PB_DIR) begin
         port_rd[PB_W-1:0] = pb_dir_reg;
      end else if (i_addr == `IOPT_ADDR_PC_DATA) begin
         port_rd[PC_W-1:0] = pc_rd;
      end else if (i_addr == `IOPT_ADDR_PC_DIR) begin
         port_rd[PC_W-1:0] = pc_dir_reg;
      end
   end

   // Bit instructions modify the read image, then write it back
   reg [7:0] sel_mask;
   reg [7:0] wr_val;
   always @* begin
      sel_mask = 8'h01 << i_bit_sel;
      wr_val = i_wdata;
      if (i_bit_op) begin
         case (i_bit_cmd)
            CMD_SET: wr_val = port_rd | sel_mask;
            CMD_CLR: wr_val = port_rd & ~sel_mask;
            CMD_CPL: wr_val = ~port_rd;
            default: wr_val = port_rd;
         endcase
      end
   end

   wire do_wr;
   assign do_wr = i_wr | i_bit_op;

   always @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         pa_data_reg <= `IOPT_PA_RST;
         pa_dir_reg <= `IOPT_PA_RST;
         pb_data_reg <= `IOPT_PB_RST;
         pb_dir_reg <= `IOPT_PB_RST;
         pc_data_reg <= `IOPT_PC_RST;
         pc_dir_reg <= `IOPT_PC_RST;
      end else if (do_wr) begin
         // Latches change only here, so they hold between writes
         if (i_addr == `IOPT_ADDR_PA_DATA) begin
            pa_data_reg <= wr_val[PA_W-1:0];
         end else if (i_addr == `IOPT_ADDR_PA_DIR) begin
            pa_dir_reg <= wr_val[PA_W-1:0];
         end else if (i_addr == `IOPT_ADDR_PB_DATA) begin
            pb_data_reg <= wr_val[PB_W-1:0];
         end else if (i_addr == `IOPT_ADDR_PB_DIR) begin
            pb_dir_reg <= wr_val[PB_W-1:0];
         end else if (i_addr == `IOPT_ADDR_PC_DATA) begin
            pc_data_reg <= wr_val[PC_W-1:0];
         end else if (i_addr == `IOPT_ADDR_PC_DIR) begin
            pc_dir_reg <= wr_val[PC_W-1:0];
         end
      end
   end

   // Read data, side functions and wake-up, all registered
   always @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= 8'h00;
         o_rvalid <= 1'b0;
         o_pullup_en <= 1'b0;
         o_wake <= 1'b0;
         o_ext_int <= 1'b1;
         o_timer_in <= 1'b1;
      end else begin
         o_rvalid <= i_rd;
         if (i_rd) begin
            o_rdata <= port_rd;
         end
         o_pullup_en <= (PULLUP_EN != 0);
         // A low level on any port A line wakes a halted core
         o_wake <= (WAKE_EN != 0) & i_halted & ~(&pa_sync);
         o_ext_int <= pc_sync[`IOPT_EXT_INT_BIT];
         o_timer_in <= pc_sync[`IOPT_TMR_IN_BIT];
      end
   end
endmodule

/* rtl/iopt_defs.vh */
`ifndef IOPT_DEFS_VH
`define IOPT_DEFS_VH

// Data memory addresses
`define IOPT_ADDR_W 8
`define IOPT_ADDR_PA_DATA 8'h12
`define IOPT_ADDR_PA_DIR 8'h13
`define IOPT_ADDR_PB_DATA 8'h14
`define IOPT_ADDR_PB_DIR 8'h15
`define IOPT_ADDR_PC_DATA 8'h16
`define IOPT_ADDR_PC_DIR 8'h17

// Implemented widths
`define IOPT_PA_W 8
`define IOPT_PB_W 3
`define IOPT_PC_W 2

// Reset values: all latches high, all lines input
`define IOPT_PA_RST 8'hFF
`define IOPT_PB_RST 3'h7
`define IOPT_PC_RST 2'h3

// Bit positions of shared pins
`define IOPT_TONE_BIT0 0
`define IOPT_TONE_BIT1 1
`define IOPT_EXT_INT_BIT 0
`define IOPT_TMR_IN_BIT 1

`endif

/* rtl/iopt_pin.v */
`timescale 1ns/1ps
// One I/O line: pad synchroniser, output drive and read mux
module iopt_pin (
   input wire i_mclk,
   input wire i_rst_n,
   input wire i_pad,
   input wire i_dir,
   input wire i_latch,
   input wire i_alt_en,
   input wire i_alt_val,
   output reg o_pad,
   output reg o_pad_oe,
   output wire o_rd,
   output wire o_sync
);
   reg meta_reg;
   reg sync_reg;

   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // Idle high like a pulled-up pad, so no false edge after reset
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         o_pad <= 1'b0;
         o_pad_oe <= 1'b0;
      end else begin
         meta_reg <= i_pad;
         sync_reg <= meta_reg;
         o_pad_oe <= ~i_dir;
         o_pad <= i_alt_en ? i_alt_val : i_latch;
      end
   end

   // Inputs are read through the two-flop synchroniser; bit instructions write the read image, inputs included, into the data latch
   assign o_rd = i_dir ? sync_reg : i_latch;
   assign o_sync = sync_reg;
endmodule

/* tb/iopt_chk.sv */
`timescale 1ns/1ps
module iopt_chk #(parameter PA_W = 8, PB_W = 3, PC_W = 2,
   parameter WAKE_EN = 1'b1, TONE_EN = 1'b1) (
   input wire i_mclk,
   input wire i_rstn,
   input wire [7:0] i_addr,
   input wire i_wr,
   input wire [7:0] i_wdata,
   input wire i_rd,
   input wire i_timer_ovf,
   input wire i_halted,
   input wire [PA_W-1:0] i_pa_pad,
   input wire [PC_W-1:0] i_pc_pad,
   input wire [7:0] o_rdata,
   input wire o_rvalid,
   input wire [PA_W-1:0] o_pa_oe,
   input wire [PB_W-1:0] o_pb_pad,
   input wire [PB_W-1:0] o_pb_oe,
   input wire o_wake,
   input wire o_ext_int,
   input wire o_timer_in
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   property p_rd; i_rd |=> o_rvalid; endproperty
   a_rd: assert property (p_rd)
      else $error("read not answered");
   property p_pb_hi; o_rvalid && $past(i_addr) == 8'h14
      |-> o_rdata[7:3] == 5'h00; endproperty
   a_pb_hi: assert property (p_pb_hi)
      else $error("port b upper bits set");
   property p_pc_hi; o_rvalid && $past(i_addr) == 8'h16
      |-> o_rdata[7:2] == 6'h00; endproperty
   a_pc_hi: assert property (p_pc_hi)
      else $error("port c upper bits set");
   property p_dir; i_wr && i_addr == 8'h13
      |-> ##2 o_pa_oe == ~$past(i_wdata, 2); endproperty
   a_dir: assert property (p_dir)
      else $error("direction not applied");
   property p_wake; (i_halted && $stable(i_pa_pad) && !(&i_pa_pad))[*4]
      |-> o_wake || !WAKE_EN; endproperty
   a_wake: assert property (p_wake)
      else $error("no wake");
   property p_wake_why; o_wake |-> $past(i_halted); endproperty
   a_wake_why: assert property (p_wake_why)
      else $error("wake while running");
   property p_tone_x; TONE_EN && o_pb_oe[1:0] == 2'b11
      |-> !(o_pb_pad[0] && o_pb_pad[1]); endproperty
   a_tone_x: assert property (p_tone_x)
      else $error("tone pair not complementary");
   property p_tone_t; TONE_EN && i_timer_ovf && o_pb_oe[1:0] == 2'b11
      && o_pb_pad[1:0] != 2'b00
      |-> ##2 o_pb_pad[0] == $past(o_pb_pad[1], 2); endproperty
   a_tone_t: assert property (p_tone_t)
      else $error("tone did not toggle");
   property p_share; $stable(i_pc_pad)[*7]
      |-> o_ext_int == i_pc_pad[0] && o_timer_in == i_pc_pad[1]; endproperty
   a_share: assert property (p_share)
      else $error("shared pin mismatch");
endmodule

/* tb/iopt_board.sv */
`timescale 1ns/1ps
module iopt_board #(parameter W = 8) (
   input wire i_mclk,
   input wire i_pullup,
   input wire [W-1:0] i_out,
   input wire [W-1:0] i_oe,
   input wire [W-1:0] i_ext_en,
   input wire [W-1:0] i_ext_val,
   output wire [W-1:0] o_pad
);
   // Undriven lines without pull-up wander, so no level can be trusted
   reg [W-1:0] float_reg = {W{1'b0}};
   always @(posedge i_mclk) begin
      float_reg <= ~float_reg;
   end
   assign o_pad = i_oe & i_out | ~i_oe & (i_ext_en & i_ext_val |
      ~i_ext_en & (i_pullup ? {W{1'b1}} : float_reg));
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
   reg i_mclk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   reg i_bit_op = 1'b0, i_timer_ovf = 1'b0, i_halted = 1'b0;
   reg [7:0] i_addr = 8'h00, i_wdata = 8'h00, pa_en = 8'h00, pa_val = 8'h00;
   reg [1:0] i_bit_cmd = 2'h0, pc_en = 2'h0, pc_val = 2'h0;
   reg [2:0] i_bit_sel = 3'h0;
   wire [7:0] i_pa_pad, o_pa_pad, o_pa_oe, o_rdata;
   wire [2:0] i_pb_pad, o_pb_pad, o_pb_oe;
   wire [1:0] i_pc_pad, o_pc_pad, o_pc_oe;
   wire o_rvalid, o_pullup_en, o_wake, o_ext_int, o_timer_in;
   integer failures = 0, num_checks = 0;
   always #20 i_mclk = ~i_mclk;
   iopt_top dut_u (.*);
   iopt_board #(.W(8)) pa_u (.i_mclk(i_mclk), .i_pullup(o_pullup_en),
      .i_out(o_pa_pad), .i_oe(o_pa_oe), .i_ext_en(pa_en),
      .i_ext_val(pa_val), .o_pad(i_pa_pad));
   iopt_board #(.W(3)) pb_u (.i_mclk(i_mclk), .i_pullup(o_pullup_en),
      .i_out(o_pb_pad), .i_oe(o_pb_oe), .i_ext_en(3'h0),
      .i_ext_val(3'h0), .o_pad(i_pb_pad));
   iopt_board #(.W(2)) pc_u (.i_mclk(i_mclk), .i_pullup(o_pullup_en),
      .i_out(o_pc_pad), .i_oe(o_pc_oe), .i_ext_en(pc_en),
      .i_ext_val(pc_val), .o_pad(i_pc_pad));
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task idle(input integer n);
      repeat (n) @(posedge i_mclk);
      @(negedge i_mclk);
   endtask
   // Bit instruction takes command from d[4:3] and bit index from d[2:0]
   task put(input [7:0] a, input [7:0] d, input op);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_bit_cmd <= d[4:3];
      i_bit_sel <= d[2:0];
      i_wr <= !op;
      i_bit_op <= op;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      i_bit_op <= 1'b0;
   endtask
   task rdc(input [7:0] a, input [7:0] exp);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(negedge i_mclk);
      chk("o_rvalid", {7'h00, o_rvalid}, 8'h01);
      chk("o_rdata", o_rdata, exp);
   endtask
   task summarize;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge i_mclk);
      i_rstn <= 1'b1;
      idle(4);
      chk("o_pa_oe", o_pa_oe, 8'h00);
      chk("o_ext_int", {7'h00, o_ext_int}, 8'h01);
      rdc(8'h13, 8'hFF);
      rdc(8'h15, 8'h07);
      rdc(8'h17, 8'h03);
      rdc(8'h12, 8'hFF);
      $display("reset test done");
      put(8'h12, 8'h5A, 1'b0);
      put(8'h13, 8'h00, 1'b0);
      pa_en <= 8'hF0;
      pa_val <= 8'hC3;
      idle(3);
      chk("o_pa_pad", o_pa_pad, 8'h5A);
      chk("o_pa_oe", o_pa_oe, 8'hFF);
      put(8'h13, 8'hF0, 1'b0);
      idle(4);
      rdc(8'h12, 8'hCA);
      pa_val <= 8'h33;
      idle(4);
      rdc(8'h12, 8'h3A);
      $display("direction test done");
      put(8'h12, 8'h18, 1'b1);
      put(8'h13, 8'h00, 1'b0);
      idle(3);
      chk("o_pa_pad", o_pa_pad, 8'h3A);
      put(8'h12, 8'h02, 1'b1);
      rdc(8'h12, 8'h3E);
      put(8'h12, 8'h0B, 1'b1);
      rdc(8'h12, 8'h36);
      put(8'h12, 8'h10, 1'b1);
      rdc(8'h12, 8'hC9);
      put(8'h14, 8'hFF, 1'b0);
      put(8'h16, 8'hFF, 1'b0);
      rdc(8'h14, 8'h07);
      rdc(8'h16, 8'h03);
      $display("bit op test done");
      put(8'h14, 8'h01, 1'b0);
      put(8'h15, 8'h00, 1'b0);
      idle(3);
      chk("o_pb_pad", {5'h00, o_pb_pad}, 8'h02);
      chk("o_pb_oe", {5'h00, o_pb_oe}, 8'h07);
      @(posedge i_mclk);
      i_timer_ovf <= 1'b1;
      @(posedge i_mclk);
      i_timer_ovf <= 1'b0;
      idle(2);
      chk("o_pb_pad", {5'h00, o_pb_pad}, 8'h01);
      put(8'h14, 8'h02, 1'b0);
      idle(3);
      chk("o_pb_pad", {5'h00, o_pb_pad}, 8'h00);
      put(8'h15, 8'h07, 1'b0);
      idle(4);
      rdc(8'h14, 8'h07);
      $display("tone test done");
      put(8'h13, 8'hFF, 1'b0);
      pa_en <= 8'h08;
      pa_val <= 8'h00;
      i_halted <= 1'b1;
      pc_en <= 2'h3;
      pc_val <= 2'h2;
      idle(8);
      chk("o_wake", {7'h00, o_wake}, 8'h01);
      chk("o_ext_int", {7'h00, o_ext_int}, 8'h00);
      chk("o_timer_in", {7'h00, o_timer_in}, 8'h01);
      @(posedge i_mclk);
      i_halted <= 1'b0;
      idle(2);
      chk("o_wake", {7'h00, o_wake}, 8'h00);
      put(8'h17, 8'h00, 1'b0);
      idle(3);
      chk("o_pc_oe", {6'h00, o_pc_oe}, 8'h03);
      chk("o_pc_pad", {6'h00, o_pc_pad}, 8'h03);
      chk("o_pullup_en", {7'h00, o_pullup_en}, 8'h01);
      rdc(8'h16, 8'h03);
      $display("wake and shared pin test done");
      summarize;
   end
endmodule
bind iopt_top iopt_chk #(.PA_W(PA_W), .PB_W(PB_W), .PC_W(PC_W),
   .WAKE_EN(WAKE_EN), .TONE_EN(TONE_EN)) chk_u (.*);
